// ==== logic/cba_map.svh ====
// Register offsets, field positions and reset values of the address
// generator extensions. Assumes word-indexed register addresses.
`ifndef CBA_MAP_SVH
`define CBA_MAP_SVH

// ----------------------------------------
// Register word indices
// ----------------------------------------
`define CBA_OFS_CONTROL 4'h0
`define CBA_OFS_X_START 4'h1
`define CBA_OFS_X_END 4'h2
`define CBA_OFS_Y_START 4'h3
`define CBA_OFS_Y_END 4'h4
`define CBA_OFS_PIVOT 4'h5
`define CBA_OFS_TABLE_PAGE 4'h6
`define CBA_OFS_WINDOW_PAGE 4'h7
`define CBA_OFS_CORE_CONFIG 4'h8
`define CBA_OFS_STATUS 4'h9

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CBA_XSEL_LO 0
`define CBA_YSEL_LO 4
`define CBA_RSEL_LO 8
`define CBA_X_EN_BIT 15
`define CBA_Y_EN_BIT 14
`define CBA_REV_EN_BIT 15
`define CBA_WIN_EN_BIT 2
`define CBA_CFG_PAGE_BIT 7
`define CBA_SEL_OFF 4'hF

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CBA_RST_WORD 16'h0000
`define CBA_RST_PAGE 8'h00

`endif

// ==== logic/cba_pkg.sv ====
// Types shared by the address generator extensions.
// Assumes the execution logic encodes modes as listed here.
package cba_pkg;

   typedef enum logic [2:0]
   {
      CBA_MODE_INDIRECT,
      CBA_MODE_POST_INC,
      CBA_MODE_POST_DEC,
      CBA_MODE_PRE_INC,
      CBA_MODE_PRE_DEC,
      CBA_MODE_REG_OFFSET
   } cba_mode_t;

   typedef enum logic [1:0]
   {
      CBA_SPACE_X_READ,
      CBA_SPACE_X_WRITE,
      CBA_SPACE_Y
   } cba_space_t;

endpackage

// ==== logic/cba_addr_gen.sv ====
// Circular, bit-reversed and program-space address generation.
// Assumes one access request per cycle from the execution logic and a
// plain register port; all inputs are synchronous to clk_sys.
//
// What this block does
// R1 - One circular buffer each, X and Y.
// R2 - Power-of-two buffers wrap in both directions.
// R3 - Start and end registers per space.
// R4 - Buffers up to 32K words long.
// R5 - X circular needs select not 15, enable.
// R6 - Y circular needs select not 15, enable.
// R7 - Overshooting addresses still wrap correctly.
// R8 - Write back only for pre/post modify.
// R9 - Bit reversal only for X writes.
// R10 - Only the modifier is bit reversed.
// R11 - Reversal needs select, enable, increment mode.
// R12 - Software aligns reversed buffer start address.
// R13 - Pivot scaled to byte modifier.
// R14 - Byte or other modes give normal addresses.
// R15 - Pointer plus reversed pivot, LSB clear.
// R16 - Reversal beats circular on X writes.
// R17 - Software avoids read after pivot write.
// R18 - Sixteen-entry sequence mirrors four bits.
// R19 - Table page plus address, bit 7 config.
// R20 - Window page plus 15 bits, user only.
// R21 - Window needs enable bit and EA bit 15.
// R22 - Y circular addresses keep LSB clear.
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`include "cba_map.svh"

module cba_addr_gen
   import cba_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // Access request
   input wire logic req_valid,
   input wire cba_space_t req_space,
   input wire cba_mode_t req_mode,
   input wire logic [3:0] req_ptr_idx,
   input wire logic [15:0] req_ptr,
   input wire logic [15:0] req_offset,
   input wire logic req_byte,
   input wire logic req_table,
   // Access result
   output logic ea_valid,
   output logic [15:0] ea,
   output logic ptr_wb_en,
   output logic [15:0] ptr_wb_value,
   output logic circ_applied,
   output logic bitrev_applied,
   // Program-space address
   output logic prog_valid,
   output logic [23:0] prog_addr,
   output logic prog_config_space
);

   // ----------------------------------------
   // Helper functions
   // ----------------------------------------
   function automatic logic [15:0] rev16(input logic [15:0] v);
      logic [15:0] r;
      r = '0;
      for (int i = 0; i < 16; i++)
      begin
         r[i] = v[15 - i];
      end
      return r;
   endfunction

   function automatic logic [15:0] wrap(input logic [15:0] a,
      input logic [15:0] lo, input logic [15:0] hi, input logic up);
      logic [16:0] len;
      logic pow2;
      logic [15:0] r;
      len = {1'b0, hi} - {1'b0, lo} + 17'h00001;
      pow2 = ((len & (len - 17'h00001)) == 17'h00000);
      r = a;
      if ((up || pow2) && (a > hi))
      begin
         r = a - len[15:0];
      end
      else if ((!up || pow2) && (a < lo))
      begin
         r = a + len[15:0];
      end
      return r;
   endfunction

   // ----------------------------------------
   // Register file
   // ----------------------------------------
   logic [15:0] control;
   logic [15:0] x_start;
   logic [15:0] x_end;
   logic [15:0] y_start;
   logic [15:0] y_end;
   logic [15:0] pivot_reg;
   logic [7:0] table_page;
   logic [7:0] window_page;
   logic [15:0] core_config;
   logic [3:0] status;
   logic [15:0] next_control;
   logic [15:0] next_x_start;
   logic [15:0] next_x_end;
   logic [15:0] next_y_start;
   logic [15:0] next_y_end;
   logic [15:0] next_pivot_reg;
   logic [7:0] next_table_page;
   logic [7:0] next_window_page;
   logic [15:0] next_core_config;
   logic [15:0] next_reg_rdata;

   always_comb
   begin
      next_control = control;
      next_x_start = x_start;
      next_x_end = x_end;
      next_y_start = y_start;
      next_y_end = y_end;
      next_pivot_reg = pivot_reg;
      next_table_page = table_page;
      next_window_page = window_page;
      next_core_config = core_config;
      if (reg_wr)
      begin
         unique case (reg_addr)
            `CBA_OFS_CONTROL: next_control = reg_wdata;
            `CBA_OFS_X_START: next_x_start = reg_wdata; // see R3
            `CBA_OFS_X_END: next_x_end = reg_wdata;
            `CBA_OFS_Y_START: next_y_start = reg_wdata;
            `CBA_OFS_Y_END: next_y_end = reg_wdata;
            `CBA_OFS_PIVOT: next_pivot_reg = reg_wdata;
            `CBA_OFS_TABLE_PAGE: next_table_page = reg_wdata[7:0];
            `CBA_OFS_WINDOW_PAGE: next_window_page = reg_wdata[7:0];
            `CBA_OFS_CORE_CONFIG: next_core_config = reg_wdata;
            default: ;
         endcase
      end
      next_reg_rdata = '0;
      if (reg_rd)
      begin
         unique case (reg_addr)
            `CBA_OFS_CONTROL: next_reg_rdata = control;
            `CBA_OFS_X_START: next_reg_rdata = x_start;
            `CBA_OFS_X_END: next_reg_rdata = x_end;
            `CBA_OFS_Y_START: next_reg_rdata = y_start;
            `CBA_OFS_Y_END: next_reg_rdata = y_end;
            `CBA_OFS_PIVOT: next_reg_rdata = pivot_reg;
            `CBA_OFS_TABLE_PAGE: next_reg_rdata = {8'h00, table_page};
            `CBA_OFS_WINDOW_PAGE: next_reg_rdata = {8'h00, window_page};
            `CBA_OFS_CORE_CONFIG: next_reg_rdata = core_config;
            `CBA_OFS_STATUS: next_reg_rdata = {12'h000, status};
            default: next_reg_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         control <= `CBA_RST_WORD;
         x_start <= `CBA_RST_WORD;
         x_end <= `CBA_RST_WORD;
         y_start <= `CBA_RST_WORD;
         y_end <= `CBA_RST_WORD;
         pivot_reg <= `CBA_RST_WORD;
         table_page <= `CBA_RST_PAGE;
         window_page <= `CBA_RST_PAGE;
         core_config <= `CBA_RST_WORD;
         reg_rdata <= `CBA_RST_WORD;
      end
      else
      begin
         control <= next_control;
         x_start <= next_x_start;
         x_end <= next_x_end;
         y_start <= next_y_start;
         y_end <= next_y_end;
         pivot_reg <= next_pivot_reg;
         table_page <= next_table_page;
         window_page <= next_window_page;
         core_config <= next_core_config;
         reg_rdata <= next_reg_rdata;
      end
   end

   // ----------------------------------------
   // Address computation
   // ----------------------------------------
   logic [3:0] x_sel;
   logic [3:0] y_sel;
   logic [3:0] rev_sel;
   logic x_circ_on;
   logic y_circ_on;
   logic rev_on;
   logic is_x;
   logic inc_mode;

   assign x_sel = control[`CBA_XSEL_LO +: 4];
   assign y_sel = control[`CBA_YSEL_LO +: 4];
   assign rev_sel = control[`CBA_RSEL_LO +: 4];
   assign is_x = (req_space != CBA_SPACE_Y);
   assign inc_mode = (req_mode == CBA_MODE_PRE_INC)
      || (req_mode == CBA_MODE_POST_INC);
   // One buffer serves X reads and X writes; Y has its own.
   assign x_circ_on = is_x && (x_sel != `CBA_SEL_OFF) // see R1, R5
      && control[`CBA_X_EN_BIT] && (req_ptr_idx == x_sel);
   assign y_circ_on = !is_x && (y_sel != `CBA_SEL_OFF) // see R6
      && control[`CBA_Y_EN_BIT] && (req_ptr_idx == y_sel);
   assign rev_on = (req_space == CBA_SPACE_X_WRITE) // see R9, R11, R14
      && (rev_sel != `CBA_SEL_OFF) && pivot_reg[`CBA_REV_EN_BIT]
      && inc_mode && !req_byte && (req_ptr_idx == rev_sel);

   logic [15:0] next_ea;
   logic [15:0] next_wb_value;
   logic next_wb_en;
   logic next_circ;
   logic next_rev;
   logic next_prog_valid;
   logic [23:0] next_prog_addr;
   logic next_prog_cfg;
   logic next_win;

   always_comb
   begin
      logic [15:0] moved;
      logic [15:0] fixed;
      logic [15:0] rev_mod;
      logic up;
      logic pre;
      moved = req_ptr;
      fixed = req_ptr;
      rev_mod = {pivot_reg[14:0], 1'b0}; // see R13
      up = 1'b1;
      pre = 1'b0;
      next_wb_en = 1'b0;
      unique case (req_mode)
         CBA_MODE_INDIRECT:
         begin
            moved = req_ptr;
         end
         CBA_MODE_POST_INC:
         begin
            moved = req_ptr + req_offset;
            next_wb_en = 1'b1;
         end
         CBA_MODE_POST_DEC:
         begin
            moved = req_ptr - req_offset;
            up = 1'b0;
            next_wb_en = 1'b1;
         end
         CBA_MODE_PRE_INC:
         begin
            moved = req_ptr + req_offset;
            pre = 1'b1;
            next_wb_en = 1'b1;
         end
         CBA_MODE_PRE_DEC:
         begin
            moved = req_ptr - req_offset;
            up = 1'b0;
            pre = 1'b1;
            next_wb_en = 1'b1;
         end
         CBA_MODE_REG_OFFSET:
         begin
            moved = req_ptr + req_offset;
            up = !req_offset[15];
            pre = 1'b1;
         end
         default:
         begin
            moved = req_ptr;
         end
      endcase
      next_circ = 1'b0;
      next_rev = 1'b0;
      fixed = moved;
      if (rev_on)
      begin
         // Carry runs toward bit 0; pointer stays in normal order.
         fixed = rev16(rev16(req_ptr) + rev16(rev_mod)); // see R10, R15, R18
         fixed[0] = 1'b0; // see R15
         next_rev = 1'b1; // see R16
      end
      else if (x_circ_on)
      begin
         fixed = wrap(moved, x_start, x_end, up); // see R2, R4, R7
         next_circ = (req_mode != CBA_MODE_INDIRECT);
      end
      else if (y_circ_on)
      begin
         fixed = wrap(moved, y_start, y_end, up); // see R2, R7
         fixed[0] = 1'b0; // see R22
         next_circ = (req_mode != CBA_MODE_INDIRECT);
      end
      next_ea = pre ? fixed : req_ptr;
      if (!is_x && y_circ_on)
      begin
         next_ea[0] = 1'b0; // see R22
      end
      next_wb_value = fixed; // see R8
      next_prog_valid = 1'b0;
      next_prog_addr = '0;
      next_prog_cfg = 1'b0;
      next_win = 1'b0;
      if (req_table)
      begin
         next_prog_valid = 1'b1;
         next_prog_addr = {table_page, next_ea}; // see R19
         next_prog_cfg = table_page[`CBA_CFG_PAGE_BIT]; // see R19
      end
      else if (core_config[`CBA_WIN_EN_BIT] && next_ea[15]
         && (req_space != CBA_SPACE_X_WRITE)) // see R21
      begin
         next_prog_valid = 1'b1;
         next_prog_addr = {1'b0, window_page, next_ea[14:0]}; // see R20
         next_win = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ea_valid <= 1'b0;
         ea <= 16'h0000;
         ptr_wb_en <= 1'b0;
         ptr_wb_value <= 16'h0000;
         circ_applied <= 1'b0;
         bitrev_applied <= 1'b0;
         prog_valid <= 1'b0;
         prog_addr <= 24'h000000;
         prog_config_space <= 1'b0;
         status <= 4'h0;
      end
      else
      begin
         ea_valid <= req_valid;
         ea <= next_ea;
         ptr_wb_en <= req_valid && next_wb_en; // see R8
         ptr_wb_value <= next_wb_value;
         circ_applied <= req_valid && next_circ;
         bitrev_applied <= req_valid && next_rev;
         prog_valid <= req_valid && next_prog_valid;
         prog_addr <= next_prog_addr;
         prog_config_space <= req_valid && next_prog_cfg;
         if (req_valid)
         begin
            status <= {next_prog_cfg, next_win, next_rev, next_circ};
         end
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   a_x_circ_off: assert property ( // see R5
      req_valid && is_x && (x_sel == `CBA_SEL_OFF) |=> !circ_applied)
      else $error("X circular active with select 15");
   a_y_circ_off: assert property ( // see R6
      req_valid && !is_x && !control[`CBA_Y_EN_BIT] |=> !circ_applied)
      else $error("Y circular active while disabled");
   a_offset_no_wb: assert property ( // see R8
      req_valid && (req_mode == CBA_MODE_REG_OFFSET) |=> !ptr_wb_en)
      else $error("Pointer written back in offset mode");
   a_rev_x_write: assert property ( // see R9
      req_valid && (req_space != CBA_SPACE_X_WRITE) |=> !bitrev_applied)
      else $error("Bit reversal outside X writes");
   a_rev_byte_off: assert property ( // see R14
      req_valid && req_byte |=> !bitrev_applied)
      else $error("Bit reversal on byte access");
   a_rev_lsb_clear: assert property ( // see R15
      bitrev_applied |-> ptr_wb_en && !ptr_wb_value[0])
      else $error("Reversed address has LSB set");
   a_rev_priority: assert property ( // see R16
      bitrev_applied |-> !circ_applied)
      else $error("Circular and reversal both applied");
   a_table_addr: assert property ( // see R19
      req_valid && req_table |=> prog_valid
      && (prog_addr == {$past(table_page), ea})
      && (prog_config_space == $past(table_page[7])))
      else $error("Table address malformed");
   a_window_gate: assert property ( // see R21
      req_valid && !req_table && !core_config[`CBA_WIN_EN_BIT]
      |=> !prog_valid)
      else $error("Window used while disabled");
   a_y_lsb_clear: assert property ( // see R22
      req_valid && !is_x && y_circ_on |=> !ea[0] && !ptr_wb_value[0])
      else $error("Y circular address has LSB set");
   a_x_wrap_range: assert property ( // see R7
      circ_applied && ptr_wb_en && $past(is_x)
      && ($past(x_start) <= $past(x_end))
      |-> (ptr_wb_value >= $past(x_start))
      && (ptr_wb_value <= $past(x_end)))
      else $error("X wrapped pointer outside buffer");

   c_x_wrap: cover property (req_valid && x_circ_on
      && (req_mode == CBA_MODE_POST_INC) ##1 circ_applied);
   c_bitrev: cover property (req_valid && rev_on ##1 bitrev_applied);
   c_window: cover property (req_valid && !req_table ##1 prog_valid);

endmodule

// ==== tb/cba_exec_model.sv ====
// Execution-side model: issues one access request per call.
// Assumes clk_sys is the block's clock and requests are never refused.
`timescale 1ns/100ps
module cba_exec_model
   import cba_pkg::*;
(
   // Clock
   input wire logic clk_sys,
   // Access request
   output logic req_valid,
   output cba_space_t req_space,
   output cba_mode_t req_mode,
   output logic [3:0] req_ptr_idx,
   output logic [15:0] req_ptr,
   output logic [15:0] req_offset,
   output logic req_byte,
   output logic req_table
);
   initial
   begin
      {req_valid, req_byte, req_table, req_ptr_idx} = 7'h00;
      {req_ptr, req_offset} = 32'h00000000;
      req_space = CBA_SPACE_X_READ;
      req_mode = CBA_MODE_INDIRECT;
   end

   // Each request is followed by an idle cycle with req_valid low.
   task automatic issue(input cba_space_t s, input cba_mode_t m,
      input logic [3:0] i, input logic [15:0] p, input logic [15:0] o,
      input logic b, input logic t);
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req_space <= s;
      req_mode <= m;
      req_ptr_idx <= i;
      req_ptr <= p;
      req_offset <= o;
      req_byte <= b;
      req_table <= t;
      @(posedge clk_sys);
      req_valid <= 1'b0;
      req_ptr <= ~p;
      req_offset <= ~o;
   endtask
endmodule

// ==== tb/cba_addr_gen_tb.sv ====
// Self-checking bench for the address generator extensions.
// Assumes cba_exec_model drives the request port.
`timescale 1ns/100ps
`include "cba_map.svh"
module cba_addr_gen_tb
   import cba_pkg::*;
();
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   localparam cba_space_t XR = CBA_SPACE_X_READ;
   localparam cba_space_t XW = CBA_SPACE_X_WRITE;
   localparam cba_space_t YS = CBA_SPACE_Y;
   localparam cba_mode_t IND = CBA_MODE_INDIRECT;
   localparam cba_mode_t POI = CBA_MODE_POST_INC;
   localparam cba_mode_t POD = CBA_MODE_POST_DEC;
   localparam cba_mode_t PRI = CBA_MODE_PRE_INC;
   localparam cba_mode_t PRD = CBA_MODE_PRE_DEC;
   localparam cba_mode_t ROF = CBA_MODE_REG_OFFSET;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata, ea, ptr_wb_value, req_ptr, req_offset;
   logic [3:0] req_ptr_idx;
   logic req_valid, req_byte, req_table, ea_valid, ptr_wb_en;
   logic circ_applied, bitrev_applied, prog_valid, prog_config_space;
   logic [23:0] prog_addr;
   cba_space_t req_space;
   cba_mode_t req_mode;
   logic [15:0] sh [16];
   integer fails = 0;
   integer check_count = 0;
   integer seed = 32'h21b1;
   integer cycles = 0;

   always #2.5 clk_sys = ~clk_sys;

   cba_exec_model model_u (.clk_sys(clk_sys), .req_valid(req_valid),
      .req_space(req_space), .req_mode(req_mode),
      .req_ptr_idx(req_ptr_idx), .req_ptr(req_ptr),
      .req_offset(req_offset), .req_byte(req_byte), .req_table(req_table));

   cba_addr_gen dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid),
      .req_space(req_space), .req_mode(req_mode),
      .req_ptr_idx(req_ptr_idx), .req_ptr(req_ptr),
      .req_offset(req_offset), .req_byte(req_byte),
      .req_table(req_table), .ea_valid(ea_valid), .ea(ea),
      .ptr_wb_en(ptr_wb_en), .ptr_wb_value(ptr_wb_value),
      .circ_applied(circ_applied), .bitrev_applied(bitrev_applied),
      .prog_valid(prog_valid), .prog_addr(prog_addr),
      .prog_config_space(prog_config_space));

   // ----------------------------------------
   // Tasks and expectation functions
   // ----------------------------------------
   task automatic wrap_up();
      $display("checks=%0d fails=%0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         fails = fails + 1;
         wrap_up();
      end
   end

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      check_count = check_count + 1;
      if (got !== exp)
      begin
         fails = fails + 1;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   function automatic logic [15:0] wrap(input logic [15:0] v,
      input logic [15:0] lo, input logic [15:0] hi);
      wrap = v > hi ? v - (hi - lo + 16'h0001) :
         v < lo ? v + (hi - lo + 16'h0001) : v;
   endfunction

   function automatic logic [15:0] rev16(input logic [15:0] v);
      for (int k = 0; k < 16; k++)
         rev16[k] = v[15 - k];
   endfunction

   task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      if (a < 4'h9)
         sh[a] = (a == 4'h6 || a == 4'h7) ? {8'h00, d[7:0]} : d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_check(input logic [3:0] a, input logic [15:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
   endtask

   task automatic access(input cba_space_t s, input cba_mode_t m,
      input logic [3:0] i, input logic [15:0] p, input logic [15:0] o,
      input logic b, input logic t);
      logic inc, modf, wb, circ, rev, pv, y;
      logic [15:0] nxt, e;
      logic [23:0] pa;
      y = s == YS;
      inc = m == POI || m == PRI;
      modf = m != IND;
      wb = modf && m != ROF;
      rev = s == XW && inc && !b && sh[5][15] &&
         sh[0][11:8] != `CBA_SEL_OFF && sh[0][11:8] == i;
      circ = modf && !rev && i != `CBA_SEL_OFF &&
         (y ? sh[0][14] && sh[0][7:4] == i : sh[0][15] && sh[0][3:0] == i);
      nxt = inc || m == ROF ? p + o : p - o;
      if (rev)
         nxt = rev16(rev16(p) + rev16({sh[5][14:0], 1'b0})) & 16'hFFFE;
      else if (circ && y)
         nxt = wrap(nxt & 16'hFFFE, sh[3], sh[4]);
      else if (circ)
         nxt = wrap(nxt, sh[1], sh[2]);
      e = m == IND || m == POI || m == POD ? p : nxt;
      if (rev || circ && y)
         e = e & 16'hFFFE;
      pv = t || s != XW && sh[8][2] && e[15];
      pa = t ? {sh[6][7:0], e} : {1'b0, sh[7][7:0], e[14:0]};
      model_u.issue(s, m, i, p, o, b, t);
      #1;
      chk(ea_valid, 1'b1);
      chk(ea, e);
      chk(ptr_wb_en, wb);
      if (wb)
         chk(ptr_wb_value, nxt);
      chk(circ_applied, circ);
      chk(bitrev_applied, rev);
      chk(prog_valid, pv);
      if (pv)
         chk(prog_addr, pa);
      if (pv)
         chk(prog_config_space, t & sh[6][7]);
   endtask

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial
   begin
      logic [15:0] d;
      logic [15:0] p;
      logic [31:0] r;
      cba_space_t s;
      foreach (sh[k])
         sh[k] = 16'h0000;
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      for (int a = 0; a < 11; a++)
         reg_check(a[3:0], 16'h0000);
      for (int a = 0; a < 8; a++)
      begin
         d = $random(seed);
         reg_write(a[3:0], d);
         reg_check(a[3:0], sh[a]);
      end
      reg_write(4'hC, 16'hFFFF);
      reg_check(4'hC, 16'h0000);
      reg_write(`CBA_OFS_STATUS, 16'hFFFF);
      reg_check(`CBA_OFS_STATUS, 16'h0000);
      reg_write(`CBA_OFS_X_START, 16'h1000);
      reg_write(`CBA_OFS_X_END, 16'h101F);
      reg_write(`CBA_OFS_Y_START, 16'h2000);
      reg_write(`CBA_OFS_Y_END, 16'h203F);
      reg_write(`CBA_OFS_PIVOT, 16'h0000);
      reg_write(`CBA_OFS_CORE_CONFIG, 16'h0000);
      reg_write(`CBA_OFS_CONTROL, 16'hCF53);
      access(XR, POI, 4'h3, 16'h101E, 16'h0002, 1'b0, 1'b0);
      @(posedge clk_sys);
      #1;
      chk(ea_valid, 1'b0);
      access(XW, POI, 4'h3, 16'h101C, 16'h0006, 1'b0, 1'b0);
      access(XR, POD, 4'h3, 16'h1000, 16'h0002, 1'b0, 1'b0);
      access(XR, PRI, 4'h3, 16'h101E, 16'h0004, 1'b0, 1'b0);
      access(XR, PRD, 4'h3, 16'h1002, 16'h0008, 1'b0, 1'b0);
      access(XR, ROF, 4'h3, 16'h101A, 16'h0008, 1'b0, 1'b0);
      access(XR, ROF, 4'h3, 16'h1004, 16'hFFF0, 1'b0, 1'b0);
      access(XR, POI, 4'h4, 16'h101E, 16'h0002, 1'b0, 1'b0);
      access(YS, POI, 4'h5, 16'h203E, 16'h0002, 1'b0, 1'b0);
      access(YS, POI, 4'h5, 16'h2011, 16'h0002, 1'b0, 1'b0);
      access(YS, POI, 4'h3, 16'h203E, 16'h0002, 1'b0, 1'b0);
      reg_write(`CBA_OFS_CONTROL, 16'h8FFF);
      access(XR, POI, 4'hF, 16'h101E, 16'h0002, 1'b0, 1'b0);
      reg_write(`CBA_OFS_CONTROL, 16'h4F53);
      access(XR, POI, 4'h3, 16'h101E, 16'h0002, 1'b0, 1'b0);
      access(YS, POI, 4'h5, 16'h203E, 16'h0002, 1'b0, 1'b0);
      reg_write(`CBA_OFS_CONTROL, 16'h82F2);
      reg_write(`CBA_OFS_PIVOT, 16'h8008);
      for (int k = 0; k < 16; k++)
      begin
         p = 16'h0800 + (rev16(16'(k)) >> 11);
         access(XW, POI, 4'h2, p, 16'h0006, 1'b0, 1'b0);
         if (k < 15)
            chk(ptr_wb_value, 16'h0800 + (rev16(16'(k + 1)) >> 11));
      end
      access(XW, PRI, 4'h2, 16'h0810, 16'h0002, 1'b0, 1'b0);
      access(XR, POI, 4'h2, 16'h101E, 16'h0002, 1'b0, 1'b0);
      access(XW, POI, 4'h2, 16'h1011, 16'h0002, 1'b1, 1'b0);
      access(XW, POD, 4'h2, 16'h1010, 16'h0002, 1'b0, 1'b0);
      access(XW, ROF, 4'h2, 16'h1010, 16'h0002, 1'b0, 1'b0);
      reg_write(`CBA_OFS_PIVOT, 16'h0008);
      access(XW, POI, 4'h2, 16'h1010, 16'h0002, 1'b0, 1'b0);
      reg_write(`CBA_OFS_CONTROL, 16'h0FFF);
      reg_write(`CBA_OFS_TABLE_PAGE, 16'hAB85);
      reg_write(`CBA_OFS_WINDOW_PAGE, 16'h003C);
      reg_write(`CBA_OFS_CORE_CONFIG, 16'h0004);
      access(XR, IND, 4'h1, 16'h1234, 16'h0000, 1'b0, 1'b1);
      reg_check(`CBA_OFS_STATUS, 16'h0008);
      access(XR, IND, 4'h1, 16'h8ABC, 16'h0000, 1'b0, 1'b0);
      access(YS, IND, 4'h1, 16'h8ABD, 16'h0000, 1'b1, 1'b0);
      access(XR, IND, 4'h1, 16'h0ABC, 16'h0000, 1'b0, 1'b0);
      access(XW, IND, 4'h1, 16'h8ABC, 16'h0000, 1'b0, 1'b0);
      reg_write(`CBA_OFS_TABLE_PAGE, 16'h0012);
      reg_write(`CBA_OFS_CORE_CONFIG, 16'h0000);
      access(XR, IND, 4'h1, 16'hFFFE, 16'h0000, 1'b0, 1'b1);
      access(XR, IND, 4'h1, 16'h8ABC, 16'h0000, 1'b0, 1'b0);
      reg_write(`CBA_OFS_CONTROL, 16'hCF53);
      repeat (200)
      begin
         r = $random(seed);
         s = cba_space_t'(r[1:0] % 2'd3);
         p = (s == YS ? 16'h2000 : 16'h1000) + {11'h000, r[8:5], 1'b0};
         access(s, cba_mode_t'(r[4:2] % 3'd6),
            r[9] ? (s == YS ? 4'h5 : 4'h3) : r[13:10], p,
            {13'h0000, r[15:14], 1'b0}, r[16], r[17]);
      end
      wrap_up();
   end
endmodule
